// ---- design/ptd_defs.vh ----
// Purpose: Shared constants of the transmit DMA bus block.
// Assumes: 32-bit register port with byte addresses, 10 MHz core clock.
// Notes: Register offsets and field positions are named here only.
`ifndef PTD_DEFS_VH
`define PTD_DEFS_VH

`define PTD_ADDR_W 8
`define PTD_OFS_CFG 8'h00
`define PTD_OFS_IRQ_STAT 8'h04
`define PTD_OFS_IRQ_MASK 8'h08
`define PTD_OFS_LAT 8'h0C
`define PTD_OFS_TX_CONF 8'h10
`define PTD_OFS_TXDP 8'h14
`define PTD_OFS_CMD 8'h18
`define PTD_OFS_STAT 8'h1C

`define PTD_CFG_BIG 0
`define PTD_CMD_TXEN 0
`define PTD_LAT_W 8
`define PTD_LAT_RESET 8'h20
`define PTD_FILL_LSB 0
`define PTD_FILL_MSB 5
`define PTD_DRAIN_LSB 8
`define PTD_DRAIN_MSB 13
`define PTD_BURST_LSB 20
`define PTD_BURST_MSB 22
`define PTD_TX_CONF_RESET 32'h0000_0101

`define PTD_IRQ_W 3
`define PTD_IRQ_DESC 0
`define PTD_IRQ_CHAIN 1
`define PTD_IRQ_UNDER 2

`define PTD_FIFO_DEPTH 512
`define PTD_FIFO_AW 9
`define PTD_MAX_PKTS 3'h4
`define PTD_THR_SHIFT 3
`define PTD_MAX_BURST 8'h80
`define PTD_DESC_WORDS 8'h03
`define PTD_DESC_MORE 31
`define PTD_DESC_SIZE_MSB 11
`define PTD_CMD_MEMRD 4'h6
`define PTD_SYNC_W 35

`endif

// ---- design/ptd_fifo.v ----
// Purpose: Transmit data FIFO with valid and ready on both sides.
// Assumes: Single clock; width and depth are parameters.
// Notes: The output word is held in a register so the reader sees a flop.
`timescale 1ns/1ns
module ptd_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 512,
  parameter AW = 9
) (
  input wire core_clk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output reg out_valid,
  input wire out_ready,
  output reg [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] stored;
  wire push;
  wire load;

  // The output register counts as one entry, so full is honest.
  assign in_ready = (level < DEPTH);
  assign push = in_valid && in_ready;
  assign load = (stored != 0) && (!out_valid || out_ready);

  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      stored <= {(AW+1){1'b0}};
      level <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        out_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 1'b1;
        out_valid <= 1'b1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
      stored <= stored + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
      level <= level + {{AW{1'b0}}, push} - {{AW{1'b0}}, out_valid && out_ready};
    end
  end
endmodule

// ---- design/ptd_top.v ----
// Purpose: Bus-master transmit DMA, byte order, latency timer and interrupt logic.
// Assumes: Bus pins and the bus clock are sampled by the 10 MHz core clock.
// Notes: Bus pins act on detected rising edges of the sampled bus clock.
// Operation
// - Config bit 0 selects big endian, default little.
// - Byte swap only on FIFO data, never registers.
// - Open-drain active-low interrupt pin, bus independent.
// - Status register shows every pending source.
// - Any status read clears all bits except those set by an event in the same cycle.
// - Mask register gates each source off pin.
// - Eight-bit latency counter counts from frame start.
// - Keep bus until counter zero with grant removed, or done.
// - DMA host data into FIFO, feed MAC.
// - 2 KB FIFO holding up to four packets.
// - Request bus for data only on the fill threshold; descriptor reads at once.
// - Each data burst moves up to maximum burst; descriptor reads move three dwords.
// - Single or chained descriptors, separate buffers.
// - Zero wait states, bursts up to 128 dwords.
`timescale 1ns/1ns
`include "ptd_defs.vh"
module ptd_top (
  input wire core_clk,
  input wire rst,
  input wire [`PTD_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire link_clk,
  input wire gnt_n,
  input wire trdy_n_in,
  input wire [31:0] ad_in,
  output reg req_n,
  output reg [31:0] ad_out,
  output reg ad_oe_n,
  output reg [3:0] cbe_out,
  output reg cbe_oe_n,
  output reg frame_n_out,
  output reg frame_oe_n,
  output reg irdy_n_out,
  output reg irdy_oe_n,
  output reg irq_out_n,
  output reg irq_oe_n,
  output reg [31:0] tx_data,
  output reg tx_last,
  output reg tx_valid,
  input wire tx_ready
);
  localparam B_IDLE = 2'd0;
  localparam B_REQ = 2'd1;
  localparam B_DATA = 2'd2;
  localparam B_END = 2'd3;
  localparam M_IDLE = 2'd0;
  localparam M_DESC = 2'd1;
  localparam M_WAIT = 2'd2;
  localparam M_DATA = 2'd3;

  // Registers reached over the register port.
  reg big_endian_select;
  reg [`PTD_IRQ_W-1:0] interrupt_status_reg;
  reg [`PTD_IRQ_W-1:0] interrupt_mask_reg;
  reg [`PTD_LAT_W-1:0] latency_timer_value;
  reg [31:0] tx_config_reg;
  reg [31:0] tx_desc_ptr;
  reg tx_enable;

  // Pin synchroniser: s1 feeds s2 only; a bit counts once s2 and s3 agree.
  reg [`PTD_SYNC_W-1:0] sync1;
  reg [`PTD_SYNC_W-1:0] sync2;
  reg [`PTD_SYNC_W-1:0] sync3;
  reg [`PTD_SYNC_W-1:0] pin_q;
  reg clk_prev;
  wire [`PTD_SYNC_W-1:0] next_pin;
  wire link_edge;
  wire gnt_s_n;
  wire trdy_s_n;
  wire [31:0] ad_s;

  assign next_pin = (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_q);
  assign link_edge = pin_q[34] && !clk_prev;
  assign gnt_s_n = pin_q[33];
  assign trdy_s_n = pin_q[32];
  assign ad_s = pin_q[31:0];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1 <= {`PTD_SYNC_W{1'b1}};
      sync2 <= {`PTD_SYNC_W{1'b1}};
      sync3 <= {`PTD_SYNC_W{1'b1}};
      pin_q <= {`PTD_SYNC_W{1'b1}};
      clk_prev <= 1'b1;
    end else begin
      sync1 <= {link_clk, gnt_n, trdy_n_in, ad_in};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_q <= next_pin;
      clk_prev <= pin_q[34];
    end
  end

  function [31:0] swap_bytes;
    input [31:0] w;
    input big;
    begin
      swap_bytes = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    end
  endfunction

  // Burst code 0 means the full 128 dwords, code n means 2**(n-1) dwords.
  function [7:0] burst_words;
    input [2:0] code;
    begin
      if (code == 3'h0) begin
        burst_words = `PTD_MAX_BURST;
      end else begin
        burst_words = 8'h01 << (code - 3'h1);
      end
    end
  endfunction

  function [9:0] min3;
    input [9:0] a;
    input [9:0] b;
    input [9:0] c;
    reg [9:0] m;
    begin
      m = (a < b) ? a : b;
      min3 = (m < c) ? m : c;
    end
  endfunction

  // FIFO and packet accounting.
  wire [32:0] fifo_out;
  wire fifo_out_valid;
  wire fifo_in_ready;
  wire fifo_out_ready;
  wire [`PTD_FIFO_AW:0] fifo_level;
  reg fifo_push;
  reg [32:0] fifo_word;
  reg [2:0] pkt_count;
  reg draining;
  wire [9:0] free_words;
  wire [9:0] fill_words;
  wire [9:0] drain_words;
  wire drain_ok;
  wire pop_last;

  // The difference is formed at full width and cut on purpose; it never exceeds the depth.
  wire [31:0] free_full;
  assign free_full = `PTD_FIFO_DEPTH - {22'h00_0000, fifo_level};
  assign free_words = free_full[9:0];
  assign fill_words = {4'h0, tx_config_reg[`PTD_FILL_MSB:`PTD_FILL_LSB]} << `PTD_THR_SHIFT;
  assign drain_words = {4'h0, tx_config_reg[`PTD_DRAIN_MSB:`PTD_DRAIN_LSB]} << `PTD_THR_SHIFT;
  assign drain_ok = draining || (pkt_count != 3'h0) ||
                    (fifo_level >= drain_words);
  assign fifo_out_ready = (!tx_valid || tx_ready) && drain_ok;
  assign pop_last = fifo_out_valid && fifo_out_ready && fifo_out[32];

  ptd_fifo #(
    .WIDTH(33),
    .DEPTH(`PTD_FIFO_DEPTH),
    .AW(`PTD_FIFO_AW)
  ) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(fifo_word),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .level(fifo_level)
  );

  // Bus master engine and main sequencer.
  reg [1:0] bstate;
  reg [1:0] mstate;
  reg [`PTD_LAT_W-1:0] lat_count;
  reg [9:0] words_left;
  reg [9:0] moved;
  reg bus_go;
  reg bus_done;
  reg bus_desc;
  reg [31:0] bus_addr;
  reg [9:0] bus_len;
  reg [31:0] desc_link;
  reg [31:0] desc_buf;
  reg [31:0] desc_cmd;
  reg [9:0] data_left;
  reg [1:0] desc_idx;
  reg [`PTD_IRQ_W-1:0] irq_event;
  wire take_word;
  wire stop_now;
  wire [9:0] chunk;

  assign take_word = link_edge && (bstate == B_DATA) && !irdy_n_out && !trdy_s_n;
  assign stop_now = (words_left == 10'h2) || (gnt_s_n && lat_count == {`PTD_LAT_W{1'b0}});
  assign chunk = min3(data_left, {2'b00, burst_words(
                 tx_config_reg[`PTD_BURST_MSB:`PTD_BURST_LSB])}, free_words);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bstate <= B_IDLE;
      req_n <= 1'b1;
      ad_out <= 32'h0000_0000;
      ad_oe_n <= 1'b1;
      cbe_out <= 4'h0;
      cbe_oe_n <= 1'b1;
      frame_n_out <= 1'b1;
      frame_oe_n <= 1'b1;
      irdy_n_out <= 1'b1;
      irdy_oe_n <= 1'b1;
      lat_count <= {`PTD_LAT_W{1'b0}};
      words_left <= 10'h000;
      moved <= 10'h000;
      bus_done <= 1'b0;
      fifo_push <= 1'b0;
      fifo_word <= 33'h0_0000_0000;
      desc_idx <= 2'h0;
      desc_link <= 32'h0000_0000;
      desc_buf <= 32'h0000_0000;
      desc_cmd <= 32'h0000_0000;
    end else begin
      bus_done <= 1'b0;
      fifo_push <= 1'b0;
      if (link_edge && bstate != B_IDLE && bstate != B_REQ) begin
        if (lat_count != {`PTD_LAT_W{1'b0}}) begin
          lat_count <= lat_count - 1'b1;
        end
      end
      if (take_word) begin
        moved <= moved + 10'h001;
        words_left <= words_left - 10'h001;
        if (bus_desc) begin
          desc_idx <= desc_idx + 2'h1;
          case (desc_idx)
            2'h0: desc_link <= ad_s;
            2'h1: desc_buf <= ad_s;
            default: desc_cmd <= ad_s;
          endcase
        end else begin
          fifo_push <= 1'b1;
          // Last word of a burst that covers all that is left of the buffer, in a descriptor without the more bit.
          fifo_word <= {(words_left == 10'h1) && (data_left == bus_len) &&
                        !desc_cmd[`PTD_DESC_MORE], swap_bytes(ad_s, big_endian_select)};
        end
      end
      case (bstate)
        B_IDLE: begin
          if (bus_go) begin
            req_n <= 1'b0;
            moved <= 10'h000;
            desc_idx <= 2'h0;
            words_left <= bus_len;
            bstate <= B_REQ;
          end
        end
        B_REQ: begin
          if (link_edge && !gnt_s_n) begin
            frame_n_out <= 1'b0;
            frame_oe_n <= 1'b0;
            ad_out <= bus_addr;
            ad_oe_n <= 1'b0;
            cbe_out <= `PTD_CMD_MEMRD;
            cbe_oe_n <= 1'b0;
            lat_count <= latency_timer_value;
            bstate <= B_DATA;
          end
        end
        B_DATA: begin
          if (link_edge) begin
            ad_oe_n <= 1'b1;
            cbe_out <= 4'h0;
            irdy_oe_n <= 1'b0;
            // A wait state is inserted during data reads while the FIFO cannot take a word.
            irdy_n_out <= !(bus_desc || fifo_in_ready);
            if (words_left == 10'h1) begin
              frame_n_out <= 1'b1;
            end
            if (take_word) begin
              if (frame_n_out || words_left == 10'h1) begin
                irdy_n_out <= 1'b1;
                req_n <= 1'b1;
                bstate <= B_END;
              end else if (stop_now) begin
                frame_n_out <= 1'b1;
              end
            end
          end
        end
        default: begin
          if (link_edge) begin
            frame_oe_n <= 1'b1;
            irdy_oe_n <= 1'b1;
            cbe_oe_n <= 1'b1;
            bus_done <= 1'b1;
            bstate <= B_IDLE;
          end
        end
      endcase
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mstate <= M_IDLE;
      bus_go <= 1'b0;
      bus_desc <= 1'b0;
      bus_addr <= 32'h0000_0000;
      bus_len <= 10'h000;
      data_left <= 10'h000;
      irq_event <= {`PTD_IRQ_W{1'b0}};
    end else begin
      bus_go <= 1'b0;
      irq_event <= {`PTD_IRQ_W{1'b0}};
      case (mstate)
        M_IDLE: begin
          if (tx_enable && tx_desc_ptr != 32'h0000_0000 && pkt_count < `PTD_MAX_PKTS) begin
            bus_desc <= 1'b1;
            bus_addr <= tx_desc_ptr;
            bus_len <= {2'b00, `PTD_DESC_WORDS};
            bus_go <= 1'b1;
            mstate <= M_DESC;
          end
        end
        M_DESC: begin
          if (bus_done) begin
            if (moved != {2'b00, `PTD_DESC_WORDS}) begin
              mstate <= M_IDLE;
            end else begin
              data_left <= {9'h000, desc_cmd[1:0] != 2'b00} +
                           desc_cmd[`PTD_DESC_SIZE_MSB:2];
              bus_addr <= desc_buf;
              mstate <= M_WAIT;
            end
          end
        end
        M_WAIT: begin
          if (data_left == 10'h000) begin
            irq_event[`PTD_IRQ_DESC] <= 1'b1;
            irq_event[`PTD_IRQ_CHAIN] <= (desc_link == 32'h0000_0000);
            mstate <= M_IDLE;
          end else if (free_words >= fill_words && free_words != 10'h000) begin
            bus_desc <= 1'b0;
            bus_len <= chunk;
            bus_go <= 1'b1;
            mstate <= M_DATA;
          end
        end
        default: begin
          if (bus_done) begin
            data_left <= data_left - moved;
            bus_addr <= bus_addr + {20'h0_0000, moved, 2'b00};
            mstate <= M_WAIT;
          end
        end
      endcase
      if (tx_valid && tx_ready && !tx_last && !fifo_out_valid) begin
        irq_event[`PTD_IRQ_UNDER] <= 1'b1;
      end
    end
  end

  // MAC side output stage and packet count.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_data <= 32'h0000_0000;
      tx_last <= 1'b0;
      pkt_count <= 3'h0;
      draining <= 1'b0;
    end else begin
      if (fifo_out_ready) begin
        tx_valid <= fifo_out_valid;
        tx_data <= fifo_out[31:0];
        tx_last <= fifo_out[32];
        if (fifo_out_valid) begin
          draining <= !fifo_out[32];
        end
      end else if (tx_ready) begin
        tx_valid <= 1'b0;
      end
      pkt_count <= pkt_count + {2'b00, fifo_push && fifo_word[32]} - {2'b00, pop_last};
    end
  end

  // Register port; any status read clears it, but a new event wins.
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      big_endian_select <= 1'b0;
      interrupt_status_reg <= {`PTD_IRQ_W{1'b0}};
      interrupt_mask_reg <= {`PTD_IRQ_W{1'b0}};
      latency_timer_value <= `PTD_LAT_RESET;
      tx_config_reg <= `PTD_TX_CONF_RESET;
      tx_desc_ptr <= 32'h0000_0000;
      tx_enable <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      irq_out_n <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      interrupt_status_reg <= ((reg_rd && reg_addr == `PTD_OFS_IRQ_STAT) ?
                              {`PTD_IRQ_W{1'b0}} : interrupt_status_reg) | irq_event;
      irq_oe_n <= ~|(interrupt_status_reg & interrupt_mask_reg);
      if (irq_event[`PTD_IRQ_CHAIN]) begin
        tx_enable <= 1'b0;
      end
      if (mstate == M_WAIT && data_left == 10'h000) begin
        tx_desc_ptr <= desc_link;
      end
      if (reg_wr) begin
        case (reg_addr)
          `PTD_OFS_CFG: big_endian_select <= reg_wdata[`PTD_CFG_BIG];
          `PTD_OFS_IRQ_MASK: interrupt_mask_reg <= reg_wdata[`PTD_IRQ_W-1:0];
          `PTD_OFS_LAT: latency_timer_value <= reg_wdata[`PTD_LAT_W-1:0];
          `PTD_OFS_TX_CONF: tx_config_reg <= reg_wdata;
          `PTD_OFS_TXDP: tx_desc_ptr <= reg_wdata;
          `PTD_OFS_CMD: tx_enable <= reg_wdata[`PTD_CMD_TXEN];
          default: tx_enable <= tx_enable;
        endcase
      end
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        case (reg_addr)
          `PTD_OFS_CFG: reg_rdata <= {31'h0000_0000, big_endian_select};
          `PTD_OFS_IRQ_STAT: reg_rdata <= {29'h0000_0000, interrupt_status_reg};
          `PTD_OFS_IRQ_MASK: reg_rdata <= {29'h0000_0000, interrupt_mask_reg};
          `PTD_OFS_LAT: reg_rdata <= {24'h00_0000, latency_timer_value};
          `PTD_OFS_TX_CONF: reg_rdata <= tx_config_reg;
          `PTD_OFS_TXDP: reg_rdata <= tx_desc_ptr;
          `PTD_OFS_CMD: reg_rdata <= {31'h0000_0000, tx_enable};
          `PTD_OFS_STAT: reg_rdata <= {pkt_count, 3'h0, fifo_level, lat_count,
                                       2'b00, bstate, 2'b00, mstate};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ---- tb/ptd_top_sva.sv ----
// Purpose: Port-level checks of the transmit DMA bus block.
// Assumes: One core_clk domain with rst active high.
// Notes: Bound to every ptd_top instance.
`timescale 1ns/1ns
`include "ptd_defs.vh"
module ptd_top_sva (
  input wire core_clk,
  input wire rst,
  input wire [`PTD_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire req_n,
  input wire ad_oe_n,
  input wire [3:0] cbe_out,
  input wire cbe_oe_n,
  input wire frame_n_out,
  input wire frame_oe_n,
  input wire irdy_n_out,
  input wire irq_out_n,
  input wire irq_oe_n,
  input wire [31:0] tx_data,
  input wire tx_last,
  input wire tx_valid,
  input wire tx_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_irq_level;
    irq_out_n == 1'b0;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq pin value not low");
  property p_mask_off;
    reg_wr && reg_addr == `PTD_OFS_IRQ_MASK && reg_wdata[2:0] == 3'h0 |-> ##2 irq_oe_n;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("masked irq still drives");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx word dropped while stalled");
  property p_addr_phase;
    !ad_oe_n |-> !frame_n_out && !frame_oe_n && !cbe_oe_n && cbe_out == `PTD_CMD_MEMRD;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase malformed");
  property p_addr_hold;
    $fell(ad_oe_n) |-> (!ad_oe_n) [*7];
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address not held a bus clock");
  property p_irdy_late;
    $fell(frame_n_out) |-> irdy_n_out;
  endproperty
  a_irdy_late: assert property (p_irdy_late) else $error("irdy low in address phase");
  property p_frame_req;
    $fell(frame_n_out) |-> !req_n;
  endproperty
  a_frame_req: assert property (p_frame_req) else $error("frame without request");
  property p_release;
    $rose(frame_oe_n) |-> frame_n_out && irdy_n_out && req_n;
  endproperty
  a_release: assert property (p_release) else $error("bus released mid transfer");
  c_frame: cover property ($fell(frame_n_out));
  c_last: cover property (tx_valid && tx_ready && tx_last);
  c_irq: cover property ($fell(irq_oe_n));
endmodule
bind ptd_top ptd_top_sva CHK (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .req_n(req_n), .ad_oe_n(ad_oe_n), .cbe_out(cbe_out), .cbe_oe_n(cbe_oe_n),
  .frame_n_out(frame_n_out), .frame_oe_n(frame_oe_n), .irdy_n_out(irdy_n_out),
  .irq_out_n(irq_out_n), .irq_oe_n(irq_oe_n), .tx_data(tx_data), .tx_last(tx_last),
  .tx_valid(tx_valid), .tx_ready(tx_ready));

// ---- tb/ptd_host_model.sv ----
// Purpose: Host bus model with arbiter and word memory.
// Assumes: Bus clock of 800 ns made here; memory index is address bits 9:2.
// Notes: Inputs other than gnt_n change on the falling bus clock so they are settled at the rising one.
`timescale 1ns/1ns
module ptd_host_model (
  output logic link_clk,
  output logic gnt_n,
  output logic trdy_n_in,
  output wire [31:0] ad_in,
  input wire req_n,
  input wire [31:0] ad_out,
  input wire ad_oe_n,
  input wire frame_n_out,
  input wire frame_oe_n,
  input wire irdy_n_out,
  input wire irdy_oe_n,
  input wire slow
);
  logic [31:0] mem [0:255];
  logic [31:0] addr;
  logic [31:0] rdat;
  logic tgt_on;
  logic ph;
  int wcnt;
  int max_data_burst;
  // A released bus shows the inverse of the last word so stale data never passes.
  assign ad_in = !ad_oe_n ? ad_out : (tgt_on ? rdat : ~rdat);
  initial begin
    {gnt_n, trdy_n_in, link_clk, tgt_on, ph} = 5'h18;
    {addr, rdat, wcnt, max_data_burst} = 0;
    forever #400 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    gnt_n <= req_n;
    if (!frame_oe_n && !frame_n_out && !ad_oe_n) begin
      addr <= ad_out;
      wcnt <= 0;
    end else if (!irdy_n_out && !trdy_n_in) begin
      addr <= addr + 32'h0000_0004;
      wcnt <= wcnt + 1;
      if (addr >= 32'h0000_0200 && wcnt >= max_data_burst) max_data_burst <= wcnt + 1;
    end
  end
  always @(negedge link_clk) begin
    tgt_on <= !irdy_oe_n;
    ph <= ~ph;
    trdy_n_in <= irdy_oe_n || (slow && ph);
    rdat <= mem[addr[9:2]];
  end
endmodule

// ---- tb/ptd_top_tb.sv ----
// Purpose: Register and transmit DMA scenarios for the bus block.
// Assumes: 10 MHz core clock; the host model supplies descriptors and data.
// Notes: The MAC side stalls every third cycle.
`timescale 1ns/1ns
`include "ptd_defs.vh"
module ptd_top_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [`PTD_ADDR_W-1:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_ready = 1'b0;
  logic slow = 1'b0;
  wire [31:0] reg_rdata, ad_in, ad_out, tx_data;
  wire [3:0] cbe_out;
  wire link_clk, gnt_n, trdy_n_in, req_n, ad_oe_n, cbe_oe_n, frame_n_out, frame_oe_n;
  wire irdy_n_out, irdy_oe_n, irq_out_n, irq_oe_n, tx_last, tx_valid;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [32:0] txq [$];
  logic [7:0] ofs [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [0:6] = '{0, 0, 0, 32'h0000_0020, 32'h0000_0101, 0, 0};
  ptd_top DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_clk(link_clk),
    .gnt_n(gnt_n), .trdy_n_in(trdy_n_in), .ad_in(ad_in), .req_n(req_n), .ad_out(ad_out),
    .ad_oe_n(ad_oe_n), .cbe_out(cbe_out), .cbe_oe_n(cbe_oe_n), .frame_n_out(frame_n_out),
    .frame_oe_n(frame_oe_n), .irdy_n_out(irdy_n_out), .irdy_oe_n(irdy_oe_n),
    .irq_out_n(irq_out_n), .irq_oe_n(irq_oe_n), .tx_data(tx_data), .tx_last(tx_last),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  ptd_host_model PEER (.link_clk(link_clk), .gnt_n(gnt_n), .trdy_n_in(trdy_n_in),
    .ad_in(ad_in), .req_n(req_n), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
    .frame_n_out(frame_n_out), .frame_oe_n(frame_oe_n), .irdy_n_out(irdy_n_out),
    .irdy_oe_n(irdy_oe_n), .slow(slow));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    tx_ready <= (cyc % 3) != 0;
    if (tx_valid && tx_ready) txq.push_back({tx_last, tx_data});
  end
  task automatic close_out();
    $display("mismatches %0d of %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic bad(input string msg);
    error_cnt++;
    $display("BAD %0t %s", $time, msg);
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string msg);
    comparisons++;
    if (got !== exp) bad($sformatf("%s got %h want %h", msg, got, exp));
  endtask
  task automatic chk_pin(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) bad(msg);
  endtask
  task automatic wr(input logic [`PTD_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [`PTD_ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic rd_chk(input logic [`PTD_ADDR_W-1:0] a, input logic [31:0] e, input string m);
    logic [31:0] d;
    rd(a, d);
    chk({1'b0, d}, {1'b0, e}, m);
  endtask
  // Sends the four buffer words 0x200..0x20C and compares the MAC stream.
  task automatic run_pkt(input logic big);
    int i;
    int k;
    logic [31:0] w;
    logic [31:0] d;
    txq.delete();
    wr(`PTD_OFS_CMD, 32'h0000_0001);
    for (k = 0; k < 5000 && txq.size() < 4; k++) @(posedge core_clk);
    if (txq.size() < 4) begin
      bad("tx stream short");
      close_out();
    end
    for (i = 0; i < 4; i++) begin
      w = PEER.mem[128 + i];
      if (big) w = {w[7:0], w[15:8], w[23:16], w[31:24]};
      chk(txq[i], {i == 3, w}, "tx word");
    end
    d = 32'h0000_0001;
    for (k = 0; k < 300 && d[0]; k++) rd(`PTD_OFS_CMD, d);
    chk_pin(d[0], 1'b0, "tx enable stays set");
  endtask
  initial begin
    int i;
    logic [31:0] d;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) rd_chk(ofs[i], rv[i], "reset value");
    rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    wr(`PTD_OFS_TXDP, 32'h8000_0104);
    rd_chk(`PTD_OFS_TXDP, 32'h8000_0104, "register bit order");
    PEER.mem[64] = 32'h0000_0000;
    PEER.mem[65] = 32'h0000_0200;
    PEER.mem[66] = 32'h0000_0010;
    for (i = 0; i < 4; i++) PEER.mem[128 + i] = 32'hA1B2_C300 + 32'(i);
    wr(`PTD_OFS_IRQ_MASK, 32'h0000_0007);
    wr(`PTD_OFS_LAT, 32'h0000_0002);
    wr(`PTD_OFS_TX_CONF, 32'h0020_0101);
    wr(`PTD_OFS_TXDP, 32'h0000_0100);
    run_pkt(1'b0);
    chk_pin(irq_oe_n, 1'b0, "irq not raised");
    rd_chk(`PTD_OFS_IRQ_STAT, 32'h0000_0003, "status causes");
    rd_chk(`PTD_OFS_IRQ_STAT, 32'h0000_0000, "status not cleared");
    chk_pin(irq_oe_n, 1'b1, "irq not released");
    chk(33'(PEER.max_data_burst), 33'h0_0000_0002, "burst size");
    rd(`PTD_OFS_STAT, d);
    chk(33'(d[15:8]), 33'h0_0000_0000, "latency count");
    // Second packet: two chained descriptors, big endian, masked, slow target.
    PEER.mem[64] = 32'h0000_0120;
    PEER.mem[66] = 32'h8000_0008;
    PEER.mem[72] = 32'h0000_0000;
    PEER.mem[73] = 32'h0000_0208;
    PEER.mem[74] = 32'h0000_0008;
    @(posedge core_clk);
    slow <= 1'b1;
    wr(`PTD_OFS_CFG, 32'h0000_0001);
    wr(`PTD_OFS_IRQ_MASK, 32'h0000_0000);
    wr(`PTD_OFS_TXDP, 32'h0000_0100);
    run_pkt(1'b1);
    chk_pin(irq_oe_n, 1'b1, "masked irq drives");
    rd_chk(`PTD_OFS_IRQ_STAT, 32'h0000_0003, "chained causes");
    close_out();
  end
endmodule
